// ### verilog/flash_device.sv
// flash device end: command decode, data buffer, page read, program and erase
// How it works
// [RULE1] page read: D2H, three address, four dummy bytes
// [RULE2] page read wraps within the same page
// [RULE3] chip select rising ends read, output floats
// [RULE4] page read uses array, buffer untouched
// [RULE5] buffer read opcodes D4H and D1H
// [RULE6] buffer address: low 9 or 8 bits
// [RULE7] one dummy byte before buffer data out
// [RULE8] host holds chip select low whole frame
// [RULE9] buffer read wraps to location zero
// [RULE10] buffer write 84H, address is start byte
// [RULE11] write stores successive bytes, wraps, until deselect
// [RULE12] program with erase 83H, 10-bit page field
// [RULE13] 83H erases page then copies buffer
// [RULE14] 88H programs buffer without erase
// [RULE15] host erases page before 88H
// [RULE16] 81H page erase to all ones
// [RULE17] 50H block erase, seven block bits
// [RULE18] block erase clears eight aligned pages
// [RULE19] busy reported during timed operations
// [RULE20] msb first, sample rise, shift on fall
// [RULE21] page size selects address field layout
`timescale 1ns/1ps
module flash_device #(
  parameter int NUM_PAGES = flash_pkg::NUM_PAGES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  flash_link_if.device     link,
  input  wire logic        page_size_256_i,
  output logic             busy_o
);
  localparam int STRIDE   = flash_pkg::PAGE_BYTES_STD;
  localparam int MEM_SIZE = NUM_PAGES * STRIDE;
  localparam int MW       = $clog2(MEM_SIZE);
  localparam int BLK_LEN  = flash_pkg::PAGES_PER_BLOCK * STRIDE;

  if (NUM_PAGES < flash_pkg::PAGES_PER_BLOCK || NUM_PAGES > flash_pkg::NUM_PAGES) begin : g_bad_pages
    $error("flash_device: NUM_PAGES out of range");
  end

  logic [7:0] mem   [MEM_SIZE];
  logic [7:0] dbuf  [STRIDE];

  // link inputs cross from the host's timing, two flops each
  logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, si_s1, si_s2;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      {cs_s1, cs_s2, cs_d} <= 3'b111;
      {sck_s1, sck_s2, sck_d, si_s1, si_s2} <= 5'b0_0000;
    end else begin
      cs_s1  <= link.cs_n;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      sck_s1 <= link.sck;
      sck_s2 <= sck_s1;
      sck_d  <= sck_s2;
      si_s1  <= link.si;
      si_s2  <= si_s1;
    end
  end

  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
  assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;
  assign cs_rise  = cs_s2 & ~cs_d;

  function automatic logic [8:0] next_ptr(input logic [8:0] p, input logic bin);
    logic [8:0] last;
    last = bin ? 9'(flash_pkg::PAGE_BYTES_BIN - 1) : 9'(flash_pkg::PAGE_BYTES_STD - 1);
    return (p >= last) ? 9'h000 : 9'(p + 9'h001);
  endfunction : next_ptr

  // frame state
  logic [2:0]  bit_cnt_reg, bit_cnt_next;
  logic [3:0]  byte_cnt_reg, byte_cnt_next;
  logic [7:0]  in_sr_reg, in_sr_next;
  logic [7:0]  opcode_reg, opcode_next;
  logic [15:0] addr_hi_reg, addr_hi_next;
  logic [8:0]  ptr_reg, ptr_next;
  logic [9:0]  page_reg, page_next;
  logic [7:0]  out_sr_reg, out_sr_next;
  logic        out_en_reg, out_en_next;
  logic        so_reg, so_next;
  logic        so_oe_n_reg, so_oe_n_next;
  // timed operation state
  flash_pkg::op_state_t op_state_reg, op_state_next;
  logic [7:0]  op_kind_reg, op_kind_next;
  logic [MW-1:0] op_base_reg, op_base_next;
  logic [11:0] walk_reg, walk_next;
  logic [11:0] walk_last_reg, walk_last_next;
  logic [10:0] wait_reg, wait_next;

  logic [7:0]  rx_byte;
  logic        byte_done, is_buf_read, is_read, load_out, buf_wr;
  logic [23:0] addr_full;
  logic [9:0]  addr_page;
  logic [MW-1:0] rd_idx, walk_idx;
  logic [7:0]  walk_val;
  logic        walk_wr;

  assign rx_byte     = {in_sr_reg[6:0], si_s2};                                         // RULE20
  assign byte_done   = sck_rise && (bit_cnt_reg == 3'h7);
  assign addr_full   = {addr_hi_reg, rx_byte};
  assign addr_page   = page_size_256_i ? addr_full[17:8] : addr_full[18:9];             // RULE21
  assign is_buf_read = (opcode_reg == flash_pkg::OP_BUF_READ_HI) ||
                       (opcode_reg == flash_pkg::OP_BUF_READ_LO);                        // RULE5
  assign is_read     = is_buf_read || (opcode_reg == flash_pkg::OP_PAGE_READ);
  // a byte is loaded as the byte before it completes: last dummy byte for the first
  assign load_out    = byte_done && op_state_reg == flash_pkg::OP_IDLE &&
                       ((is_buf_read && byte_cnt_reg >= flash_pkg::ADDR_LAST_BYTE + 4'h1) ||  // RULE7
                        (opcode_reg == flash_pkg::OP_PAGE_READ &&
                         byte_cnt_reg >= flash_pkg::PAGE_DATA_FIRST - 4'h1));             // RULE1
  assign buf_wr      = byte_done && op_state_reg == flash_pkg::OP_IDLE &&
                       opcode_reg == flash_pkg::OP_BUF_WRITE &&
                       byte_cnt_reg >= flash_pkg::BUF_DATA_FIRST;                          // RULE11
  assign rd_idx      = MW'(page_reg * 10'(STRIDE)) + MW'(ptr_reg);                         // RULE4
  assign walk_idx    = op_base_reg + MW'(walk_reg);
  assign walk_wr     = op_state_reg == flash_pkg::OP_WALK;
  assign busy_o      = op_state_reg != flash_pkg::OP_IDLE;                                 // RULE19
  assign link.so      = so_reg;
  assign link.so_oe_n = so_oe_n_reg;

  always_comb begin
    unique case (op_kind_reg)
      flash_pkg::OP_PROG_ERASE:    walk_val = dbuf[walk_reg[8:0]];                         // RULE13
      flash_pkg::OP_PROG_NO_ERASE: walk_val = dbuf[walk_reg[8:0]] & mem[walk_idx];         // RULE14
      default:                     walk_val = flash_pkg::ERASED_BYTE;                      // RULE16
    endcase
  end

  always_comb begin
    bit_cnt_next  = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    in_sr_next    = in_sr_reg;
    opcode_next   = opcode_reg;
    addr_hi_next  = addr_hi_reg;
    ptr_next      = ptr_reg;
    page_next     = page_reg;
    out_sr_next   = out_sr_reg;
    out_en_next   = out_en_reg;
    so_next       = so_reg;
    so_oe_n_next  = so_oe_n_reg;
    if (cs_s2) begin
      bit_cnt_next  = 3'h0;
      byte_cnt_next = 4'h0;
      out_en_next   = 1'b0;
      so_oe_n_next  = 1'b1;                                                              // RULE3
    end else begin
      if (sck_rise) begin
        in_sr_next   = rx_byte;
        bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
      end
      if (byte_done) begin
        if (byte_cnt_reg != flash_pkg::BYTE_CNT_SAT)
          byte_cnt_next = 4'(byte_cnt_reg + 4'h1);
        if (byte_cnt_reg == 4'h0)
          opcode_next = rx_byte;
        else if (byte_cnt_reg < flash_pkg::ADDR_LAST_BYTE)
          addr_hi_next = {addr_hi_reg[7:0], rx_byte};
        else if (byte_cnt_reg == flash_pkg::ADDR_LAST_BYTE) begin
          page_next = addr_page;                                                        // RULE12
          ptr_next  = page_size_256_i ? {1'b0, rx_byte} : {addr_hi_reg[0], rx_byte};     // RULE6
        end
      end
      if (load_out) begin
        out_sr_next = is_buf_read ? dbuf[ptr_reg] : mem[rd_idx];
        out_en_next = 1'b1;
        ptr_next    = next_ptr(ptr_reg, page_size_256_i);                                // RULE2 RULE9
      end else if (buf_wr)
        ptr_next = next_ptr(ptr_reg, page_size_256_i);                                  // RULE10
      if (sck_fall && out_en_reg && is_read) begin
        so_next      = out_sr_reg[7];                                                     // RULE20
        out_sr_next  = {out_sr_reg[6:0], 1'b0};
        so_oe_n_next = 1'b0;
      end
    end
  end

  always_comb begin
    op_state_next  = op_state_reg;
    op_kind_next   = op_kind_reg;
    op_base_next   = op_base_reg;
    walk_next      = walk_reg;
    walk_last_next = walk_last_reg;
    wait_next      = wait_reg;
    unique case (op_state_reg)
      flash_pkg::OP_IDLE: begin
        // a program or erase starts on deselect once the address is complete
        if (cs_rise && byte_cnt_reg > flash_pkg::ADDR_LAST_BYTE) begin
          op_kind_next   = opcode_reg;
          walk_next      = 12'h000;
          walk_last_next = 12'(STRIDE - 1);
          op_base_next   = MW'(page_reg * 10'(STRIDE));
          op_state_next  = flash_pkg::OP_WALK;
          unique case (opcode_reg)
            flash_pkg::OP_PROG_ERASE:    wait_next = 11'(flash_pkg::ERASE_PROGRAM_CYC);
            flash_pkg::OP_PROG_NO_ERASE: wait_next = 11'(flash_pkg::PROGRAM_CYC);
            flash_pkg::OP_PAGE_ERASE:    wait_next = 11'(flash_pkg::PAGE_ERASE_CYC);
            flash_pkg::OP_BLOCK_ERASE: begin
              wait_next      = 11'(flash_pkg::BLOCK_ERASE_CYC);
              walk_last_next = 12'(BLK_LEN - 1);
              op_base_next   = MW'({page_reg[9:3], 3'b000} * 10'(STRIDE));               // RULE17 RULE18
            end
            default: op_state_next = flash_pkg::OP_IDLE;
          endcase
        end
      end
      flash_pkg::OP_WALK: begin
        if (walk_reg == walk_last_reg)
          op_state_next = flash_pkg::OP_WAIT;
        else
          walk_next = 12'(walk_reg + 12'h001);
      end
      flash_pkg::OP_WAIT: begin
        if (wait_reg <= 11'h001)
          op_state_next = flash_pkg::OP_IDLE;
        else
          wait_next = 11'(wait_reg - 11'h001);
      end
      default: op_state_next = flash_pkg::OP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg   <= 3'h0;
      byte_cnt_reg  <= 4'h0;
      in_sr_reg     <= 8'h00;
      opcode_reg    <= 8'h00;
      addr_hi_reg   <= 16'h0000;
      ptr_reg       <= 9'h000;
      page_reg      <= 10'h000;
      out_sr_reg    <= 8'h00;
      out_en_reg    <= 1'b0;
      so_reg        <= 1'b0;
      so_oe_n_reg   <= 1'b1;
      op_state_reg  <= flash_pkg::OP_IDLE;
      op_kind_reg   <= 8'h00;
      op_base_reg   <= '0;
      walk_reg      <= 12'h000;
      walk_last_reg <= 12'h000;
      wait_reg      <= 11'h000;
    end else begin
      bit_cnt_reg   <= bit_cnt_next;
      byte_cnt_reg  <= byte_cnt_next;
      in_sr_reg     <= in_sr_next;
      opcode_reg    <= opcode_next;
      addr_hi_reg   <= addr_hi_next;
      ptr_reg       <= ptr_next;
      page_reg      <= page_next;
      out_sr_reg    <= out_sr_next;
      out_en_reg    <= out_en_next;
      so_reg        <= so_next;
      so_oe_n_reg   <= so_oe_n_next;
      op_state_reg  <= op_state_next;
      op_kind_reg   <= op_kind_next;
      op_base_reg   <= op_base_next;
      walk_reg      <= walk_next;
      walk_last_reg <= walk_last_next;
      wait_reg      <= wait_next;
    end
  end

  // storage has no reset; erased state is loaded only by erase commands
  always_ff @(posedge clk_i) begin
    if (buf_wr)
      dbuf[ptr_reg] <= rx_byte;                                                          // RULE11
    if (walk_wr)
      mem[walk_idx] <= walk_val;                                                         // RULE13 RULE18
  end
endmodule : flash_device

// ### verilog/flash_pkg.sv
// constants shared by both ends of the serial flash link
package flash_pkg;
  localparam logic [7:0]  OP_PAGE_READ     = 8'hd2;
  localparam logic [7:0]  OP_BUF_READ_HI   = 8'hd4;
  localparam logic [7:0]  OP_BUF_READ_LO   = 8'hd1;
  localparam logic [7:0]  OP_BUF_WRITE     = 8'h84;
  localparam logic [7:0]  OP_PROG_ERASE    = 8'h83;
  localparam logic [7:0]  OP_PROG_NO_ERASE = 8'h88;
  localparam logic [7:0]  OP_PAGE_ERASE    = 8'h81;
  localparam logic [7:0]  OP_BLOCK_ERASE   = 8'h50;
  localparam logic [7:0]  ERASED_BYTE      = 8'hff;
  localparam int          PAGE_BYTES_STD   = 264;
  localparam int          PAGE_BYTES_BIN   = 256;
  localparam int          NUM_PAGES        = 1024;
  localparam int          PAGES_PER_BLOCK  = 8;
  // byte index within a frame: opcode is 0, address bytes 1..3
  localparam logic [3:0]  ADDR_LAST_BYTE   = 4'h3;
  localparam logic [3:0]  BUF_DATA_FIRST   = 4'h4;
  localparam logic [3:0]  PAGE_DATA_FIRST  = 4'h8;
  localparam logic [3:0]  BYTE_CNT_SAT     = 4'h8;
  localparam int          CLK_PERIOD_NS    = 20;
  // maximum times; actual figures are not given, plain defaults
  localparam int          ERASE_PROGRAM_TIME_NS = 20000;
  localparam int          PROGRAM_TIME_NS       = 15000;
  localparam int          PAGE_ERASE_TIME_NS    = 10000;
  localparam int          BLOCK_ERASE_TIME_NS   = 30000;
  localparam int          ERASE_PROGRAM_CYC = ERASE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int          PROGRAM_CYC       = PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int          PAGE_ERASE_CYC    = PAGE_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int          BLOCK_ERASE_CYC   = BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int          SCK_HALF_DEFAULT  = 8;
  localparam int          SCK_HALF_MIN      = 6;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_WALK = 3'b010,
    OP_WAIT = 3'b100
  } op_state_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_SHIFT = 3'b010,
    H_GAP   = 3'b100
  } host_state_t;
endpackage : flash_pkg

// ### verilog/flash_link_if.sv
// serial link between the flash device and its host
`timescale 1ns/1ps
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe_n;
  modport device (input cs_n, input sck, input si, output so, output so_oe_n);
  modport host   (output cs_n, output sck, output si, input so);
endinterface : flash_link_if

// ### verilog/flash_host.sv
// host end: frames one command, shifts header, dummies and data on the link
`timescale 1ns/1ps
module flash_host #(
  parameter int SCK_HALF = flash_pkg::SCK_HALF_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  flash_link_if.host       link,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  cmd_opcode_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [2:0]  cmd_dummy_i,
  input  wire logic [15:0] cmd_len_i,
  input  wire logic        cmd_read_i,
  input  wire logic [7:0]  wr_data_i,
  output logic             wr_take_o,
  output logic [7:0]       rd_data_o,
  output logic             rd_valid_o
);
  if (SCK_HALF < flash_pkg::SCK_HALF_MIN || SCK_HALF > 255) begin : g_bad_half
    $error("flash_host: SCK_HALF out of range");
  end

  // device output changes a few clocks after our falling edge; a long half period covers it
  logic so_s1, so_s2;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      so_s1 <= 1'b0;
      so_s2 <= 1'b0;
    end else begin
      so_s1 <= link.so;
      so_s2 <= so_s1;
    end
  end

  flash_pkg::host_state_t state_reg, state_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic        sck_reg, sck_next, cs_n_reg, cs_n_next;
  logic [7:0]  tx_reg, tx_next, rx_reg, rx_next, rd_reg, rd_next;
  logic        rd_v_reg, rd_v_next;
  logic [2:0]  bit_reg, bit_next;
  logic [16:0] byte_reg, byte_next, total_reg, total_next, data_from_reg, data_from_next;
  logic [23:0] addr_reg, addr_next;
  logic        read_reg, read_next;
  logic [16:0] nb;
  logic        nb_data;

  assign nb          = 17'(byte_reg + 17'h0_0001);
  assign nb_data     = nb >= data_from_reg;
  assign cmd_ready_o = state_reg == flash_pkg::H_IDLE;
  assign wr_take_o   = state_reg == flash_pkg::H_SHIFT && cnt_reg == 8'(SCK_HALF - 1) && sck_reg &&
                       bit_reg == 3'h7 && nb != total_reg && nb_data && !read_reg;
  assign link.cs_n   = cs_n_reg;
  assign link.sck    = sck_reg;
  assign link.si     = tx_reg[7];                                                         // RULE20
  assign rd_data_o   = rd_reg;
  assign rd_valid_o  = rd_v_reg;

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    sck_next       = sck_reg;
    cs_n_next      = cs_n_reg;
    tx_next        = tx_reg;
    rx_next        = rx_reg;
    rd_next        = rd_reg;
    rd_v_next      = 1'b0;
    bit_next       = bit_reg;
    byte_next      = byte_reg;
    total_next     = total_reg;
    data_from_next = data_from_reg;
    addr_next      = addr_reg;
    read_next      = read_reg;
    unique case (state_reg)
      flash_pkg::H_IDLE: begin
        if (cmd_valid_i) begin
          state_next     = flash_pkg::H_SHIFT;
          cs_n_next      = 1'b0;                                                          // RULE8
          tx_next        = cmd_opcode_i;
          addr_next      = cmd_addr_i;
          read_next      = cmd_read_i;
          data_from_next = 17'(17'h0_0004 + 17'(cmd_dummy_i));                            // RULE1 RULE7
          total_next     = 17'(17'h0_0004 + 17'(cmd_dummy_i) + 17'(cmd_len_i));
          byte_next      = 17'h0_0000;
          bit_next       = 3'h0;
          cnt_next       = 8'h00;
        end
      end
      flash_pkg::H_SHIFT: begin
        cnt_next = 8'(cnt_reg + 8'h01);
        if (cnt_reg == 8'(SCK_HALF - 1)) begin
          cnt_next = 8'h00;
          sck_next = ~sck_reg;
          if (!sck_reg) begin
            rx_next = {rx_reg[6:0], so_s2};                                               // RULE20
            if (bit_reg == 3'h7 && read_reg && byte_reg >= data_from_reg) begin
              rd_next   = {rx_reg[6:0], so_s2};
              rd_v_next = 1'b1;
            end
          end else if (bit_reg != 3'h7) begin
            tx_next  = {tx_reg[6:0], 1'b0};
            bit_next = 3'(bit_reg + 3'h1);
          end else begin
            bit_next  = 3'h0;
            byte_next = nb;
            if (nb == total_reg) begin
              state_next = flash_pkg::H_GAP;
              cs_n_next  = 1'b1;                                                          // RULE3
            end else if (nb < 17'h0_0004) begin
              tx_next   = nb == 17'h0_0001 ? addr_reg[23:16] : (nb == 17'h0_0002 ? addr_reg[15:8] : addr_reg[7:0]);
            end else
              tx_next   = (nb_data && !read_reg) ? wr_data_i : 8'h00;                    // RULE11
          end
        end
      end
      flash_pkg::H_GAP: begin
        cnt_next = 8'(cnt_reg + 8'h01);
        if (cnt_reg == 8'(SCK_HALF - 1)) begin
          cnt_next   = 8'h00;
          state_next = flash_pkg::H_IDLE;
        end
      end
      default: state_next = flash_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg     <= flash_pkg::H_IDLE;
      cnt_reg       <= 8'h00;
      sck_reg       <= 1'b0;
      cs_n_reg      <= 1'b1;
      tx_reg        <= 8'h00;
      rx_reg        <= 8'h00;
      rd_reg        <= 8'h00;
      rd_v_reg      <= 1'b0;
      bit_reg       <= 3'h0;
      byte_reg      <= 17'h0_0000;
      total_reg     <= 17'h0_0000;
      data_from_reg <= 17'h0_0000;
      addr_reg      <= 24'h00_0000;
      read_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      sck_reg       <= sck_next;
      cs_n_reg      <= cs_n_next;
      tx_reg        <= tx_next;
      rx_reg        <= rx_next;
      rd_reg        <= rd_next;
      rd_v_reg      <= rd_v_next;
      bit_reg       <= bit_next;
      byte_reg      <= byte_next;
      total_reg     <= total_next;
      data_from_reg <= data_from_next;
      addr_reg      <= addr_next;
      read_reg      <= read_next;
    end
  end
endmodule : flash_host

// ### bench/flash_link_props.sv
// concurrent checks on the serial link between flash host and flash device
`timescale 1ns/1ps
module flash_link_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic busy_o
);
  localparam int BUSY_MIN = 264;
  localparam int BUSY_MAX = 4000;
  logic        sck_reg;
  logic        sck_next;
  logic [15:0] rise_cnt_reg;
  logic [15:0] rise_cnt_next;
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;

  // rises are counted per frame so that whole bytes and header length can be judged
  always_comb begin
    sck_next      = sck;
    rise_cnt_next = cs_n ? 16'h0000 : rise_cnt_reg + {15'h0000, sck & ~sck_reg};
    busy_cnt_next = busy_o ? busy_cnt_reg + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sck_reg      <= 1'b0;
      rise_cnt_reg <= 16'h0000;
      busy_cnt_reg <= 16'h0000;
    end else begin
      sck_reg      <= sck_next;
      rise_cnt_reg <= rise_cnt_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  // the device sees the deselect through its synchroniser, hence the short window
  sequence s_released;
    ##[1:5] so_oe_n [*3];
  endsequence

  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock not low outside a frame");
  a_si_hold_high: assert property ((!cs_n && sck && $past(sck)) |-> $stable(si))
    else $error("serial input moved while clock high");
  a_so_hold_high: assert property ((!so_oe_n && !$past(so_oe_n) && sck && $past(sck)) |-> $stable(so))
    else $error("serial output moved while clock high");
  a_frame_whole_bytes: assert property (s_frame_end |-> rise_cnt_reg[2:0] == 3'h0 && rise_cnt_reg >= 16'h0020)
    else $error("frame not made of whole bytes after the header");
  a_float_on_deselect: assert property (s_frame_end |-> s_released)
    else $error("serial output still driven after deselect");
  a_data_after_dummy: assert property ($fell(so_oe_n) |-> !cs_n && rise_cnt_reg >= 16'h0028)
    else $error("output driven before header and dummy byte");
  a_busy_after_frame: assert property ($rose(busy_o) |-> cs_n && $past(cs_n, 2))
    else $error("busy raised inside a frame");
  a_busy_bounded: assert property (busy_o |-> busy_cnt_reg < BUSY_MAX)
    else $error("busy held too long");
  a_busy_min_walk: assert property ($fell(busy_o) |-> busy_cnt_reg >= BUSY_MIN)
    else $error("timed operation ended before a page walk");
endmodule : flash_link_props

// ### bench/serial_flash_buffer_program_erase_bench.sv
// self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
module serial_flash_buffer_program_erase_bench;
  typedef struct packed {
    logic        mode;
    logic [7:0]  op;
    logic [23:0] a;
    logic [2:0]  dm;
    logic [2:0]  n;
    logic        rd;
    logic [31:0] d;
  } row_t;
  localparam int LIMIT = 90000;
  logic        clk_i           = 1'b0;
  logic        rst_n_i         = 1'b0;
  logic        page_size_256_i = 1'b0;
  logic        cmd_valid_i     = 1'b0;
  logic [7:0]  cmd_opcode_i    = 8'h00;
  logic [23:0] cmd_addr_i      = 24'h00_0000;
  logic [2:0]  cmd_dummy_i     = 3'h0;
  logic [15:0] cmd_len_i       = 16'h0000;
  logic        cmd_read_i      = 1'b0;
  logic [7:0]  wr_data_i       = 8'h00;
  logic        busy_o;
  logic        cmd_ready_o;
  logic        wr_take_o;
  logic [7:0]  rd_data_o;
  logic        rd_valid_o;
  logic [31:0] got;
  logic [31:0] wd;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  row_t        rows [20];

  always #10 clk_i = ~clk_i;

  flash_link_if i_flash_link_if ();
  flash_device #(.NUM_PAGES(16)) i_flash_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(i_flash_link_if),
    .page_size_256_i(page_size_256_i), .busy_o(busy_o));
  flash_host #(.SCK_HALF(6)) i_flash_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(i_flash_link_if),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_opcode_i(cmd_opcode_i), .cmd_addr_i(cmd_addr_i),
    .cmd_dummy_i(cmd_dummy_i), .cmd_len_i(cmd_len_i), .cmd_read_i(cmd_read_i), .wr_data_i(wr_data_i),
    .wr_take_o(wr_take_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
  flash_link_props i_flash_link_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n(i_flash_link_if.cs_n),
    .sck(i_flash_link_if.sck), .si(i_flash_link_if.si), .so(i_flash_link_if.so),
    .so_oe_n(i_flash_link_if.so_oe_n), .busy_o(busy_o));

  // the take pulse lasts one cycle, so the next byte is put up at its falling edge
  always @(negedge clk_i) begin
    if (wr_take_o === 1'b1) begin
      wr_data_i <= wd[31:24];
      wd <= {wd[23:0], 8'h00};
    end
    if (rd_valid_o === 1'b1) got <= {got[23:0], rd_data_o};
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t ns: %s", $time, msg);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // entered at a falling edge with the host idle; wb waits out the timed operation
  task automatic run_cmd(input row_t r, input bit wb);
    int k;
    got = 32'h0000_0000;
    wd = r.d << (32 - 8 * int'(r.n));
    page_size_256_i = r.mode;
    cmd_opcode_i = r.op;
    cmd_addr_i = r.a;
    cmd_dummy_i = r.dm;
    cmd_len_i = {13'h0000, r.n};
    cmd_read_i = r.rd;
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    for (k = 0; cmd_ready_o !== 1'b1 && k < 4000; k++) @(negedge clk_i);
    chk(k < 4000, "frame did not finish");
    repeat (8) @(negedge clk_i);
    if (r.op inside {8'h83, 8'h88, 8'h81, 8'h50}) chk(busy_o === 1'b1, "busy not reported");
    for (k = 0; wb && busy_o !== 1'b0 && k < 5000; k++) @(negedge clk_i);
    chk(k < 5000, "busy never cleared");
    if (r.rd) begin
      chk(got === r.d, "read data differs");
      chk(i_flash_link_if.so_oe_n === 1'b1, "output still driven");
    end
  endtask : run_cmd

  initial begin
    rows = '{
      '{1'b0, 8'h84, 24'h00_0106, 3'h0, 3'h4, 1'b0, 32'ha1b2_c3d4},
      '{1'b0, 8'hd4, 24'h00_0106, 3'h1, 3'h4, 1'b1, 32'ha1b2_c3d4},
      '{1'b0, 8'hd1, 24'hfe_0000, 3'h1, 3'h2, 1'b1, 32'h0000_c3d4},
      '{1'b0, 8'h83, 24'h00_0600, 3'h0, 3'h0, 1'b0, 32'h0000_0000},
      '{1'b0, 8'hd2, 24'h00_0706, 3'h4, 3'h4, 1'b1, 32'ha1b2_c3d4},
      '{1'b0, 8'h84, 24'h00_0000, 3'h0, 3'h2, 1'b0, 32'h0000_0ff0},
      '{1'b0, 8'h81, 24'h00_0600, 3'h0, 3'h0, 1'b0, 32'h0000_0000},
      '{1'b0, 8'hd2, 24'h00_0600, 3'h4, 3'h2, 1'b1, 32'h0000_ffff},
      '{1'b0, 8'h88, 24'h00_0600, 3'h0, 3'h0, 1'b0, 32'h0000_0000},
      '{1'b0, 8'hd2, 24'h00_0600, 3'h4, 3'h2, 1'b1, 32'h0000_0ff0},
      '{1'b0, 8'hd4, 24'h00_0000, 3'h1, 3'h2, 1'b1, 32'h0000_0ff0},
      '{1'b0, 8'h83, 24'h00_1200, 3'h0, 3'h0, 1'b0, 32'h0000_0000},
      '{1'b0, 8'h83, 24'h00_0e00, 3'h0, 3'h0, 1'b0, 32'h0000_0000},
      '{1'b0, 8'h50, 24'h00_1800, 3'h0, 3'h0, 1'b0, 32'h0000_0000},
      '{1'b0, 8'hd2, 24'h00_1200, 3'h4, 3'h2, 1'b1, 32'h0000_ffff},
      '{1'b0, 8'hd2, 24'h00_0e00, 3'h4, 3'h2, 1'b1, 32'h0000_0ff0},
      '{1'b1, 8'h84, 24'h00_00ff, 3'h0, 3'h2, 1'b0, 32'h0000_5aa5},
      '{1'b1, 8'hd4, 24'h00_01ff, 3'h1, 3'h2, 1'b1, 32'h0000_5aa5},
      '{1'b1, 8'h83, 24'h00_0500, 3'h0, 3'h0, 1'b0, 32'h0000_0000},
      '{1'b1, 8'hd2, 24'h00_05ff, 3'h4, 3'h2, 1'b1, 32'h0000_5aa5}
    };
    repeat (20) @(negedge clk_i);
    chk(i_flash_link_if.cs_n === 1'b1 && i_flash_link_if.sck === 1'b0 && i_flash_link_if.so_oe_n === 1'b1
      && busy_o === 1'b0 && cmd_ready_o === 1'b1 && rd_valid_o === 1'b0, "levels in reset");
    rst_n_i = 1'b1;
    @(negedge clk_i);
    foreach (rows[i]) run_cmd(rows[i], 1'b1);
    // a write sent while programming runs must leave the buffer alone
    run_cmd(row_t'{1'b1, 8'h83, 24'h00_0100, 3'h0, 3'h0, 1'b0, 32'h0000_0000}, 1'b0);
    run_cmd(row_t'{1'b1, 8'h84, 24'h00_0000, 3'h0, 3'h1, 1'b0, 32'h0000_0077}, 1'b1);
    run_cmd(row_t'{1'b1, 8'hd4, 24'h00_0000, 3'h1, 3'h1, 1'b1, 32'h0000_00a5}, 1'b1);
    complete_run();
  end
endmodule : serial_flash_buffer_program_erase_bench
